// ===== pcm_socket_mux.sv
// Socket signal multiplexer top: pin redefinition, DMA, IRQ routing, AHB regs
//
// Operation
// - DMA card with DMA on: sense-one pin's host ack drives card attribute select.
// - Ack pass-through allowed in 5 V only system or basic config with external sensing.
// - Extended configuration allows ack pass-through only with sense-one strapped high.
// - Extended configuration with sense-one strapped low: pin is EEPROM chip select.
// - Hold off cycle completion while the card asserts wait.
// - Memory card type: write-protect pin reports the write-protect switch.
// - I/O card, no 16-bit indication on wide I/O: two byte accesses.
// - An 8-bit I/O window ignores the 16-bit port indication.
// - DMA card: write-protect pin is the card DMA request.
// - Drive active-low zero-wait output to end the host cycle early.
// - Never assert zero-wait during a 16-bit I/O access.
// - Provide ten host interrupt request outputs.
// - DMA mode offers one request/acknowledge pair plus terminal count.
// - Speaker pin strap at bus reset: low selects extended, else basic.
// - Card type setting selects memory or I/O meaning of shared pins.
//
// Added by the designer: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
module pcm_socket_mux (
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Host bus side
    input wire logic bus_reset,
    input wire logic speaker_out_strap,
    input wire logic host_tc,
    output logic host_dreq,
    output logic [9:0] host_irq,
    output logic host_zws_n,
    // Host cycle request from the window decoder
    input wire logic cyc_start,
    input wire logic cyc_io,
    input wire logic cyc_wide,
    input wire logic win_8bit,
    input wire logic zws_req,
    input wire logic mem_attr_sel_n,
    input wire logic sts_change,
    output logic cyc_done,
    output logic card_cmd_active,
    output logic card_odd_byte,
    // Socket B pins
    input wire logic sock_b_volt_sense_one_i,
    output logic sock_b_volt_sense_one_o,
    output logic sock_b_volt_sense_one_oe,
    input wire logic eeprom_chip_select,
    input wire logic card_wp,
    input wire logic card_wait_n,
    input wire logic card_irq_n,
    output logic card_reg_n,
    output logic card_tc,
    output logic wp_status
);
    // ****************************************************************
    // Straps
    // ****************************************************************
    logic spkr_strap;
    logic s1_strap;

    // Speaker pin strap picks cable-driving configuration
    pcm_strap_latch #(
        .RST_VAL(pcm_pkg::SPKR_STRAP_RST)
    ) u_spkr_strap (
        .hclk(hclk),
        .hresetn(hresetn),
        .bus_reset(bus_reset),
        .pin(speaker_out_strap),
        .strap(spkr_strap)
    );

    // Sense-one pin strap, meaningful only in extended configuration
    // A bus reset without hresetn would latch our own select drive
    pcm_strap_latch #(
        .RST_VAL(pcm_pkg::S1_STRAP_RST)
    ) u_s1_strap (
        .hclk(hclk),
        .hresetn(hresetn),
        .bus_reset(bus_reset),
        .pin(sock_b_volt_sense_one_i),
        .strap(s1_strap)
    );

    // ****************************************************************
    // AHB-Lite slave and registers
    // ****************************************************************
    logic [pcm_pkg::CTRL_WIDTH-1:0] ctrl_r;
    logic [pcm_pkg::IRQ_WIDTH-1:0] irq_r;
    logic wr_pend_r;
    logic [7:0] wr_addr_r;
    logic [31:0] stat_word;

    // Low byte decode only: the words alias every 256 bytes
    // Keep hsel confined to this block's range
    // Address phase decode; only whole-word transfers reach the registers
    wire addr_ok = hsel && hready && htrans[1];
    wire word_ok = (hsize == 3'h2);
    wire hit_ctrl = (haddr[7:0] == pcm_pkg::CTRL_OFS);
    wire hit_irq = (haddr[7:0] == pcm_pkg::IRQ_OFS);
    wire hit_stat = (haddr[7:0] == pcm_pkg::STAT_OFS);
    wire wr_ctrl = wr_pend_r && (wr_addr_r == pcm_pkg::CTRL_OFS);
    wire wr_irq = wr_pend_r && (wr_addr_r == pcm_pkg::IRQ_OFS);
    wire [31:0] rd_word = !word_ok ? 32'h0000_0000 :
        hit_ctrl ? {27'h0000000, ctrl_r} :
        hit_irq ? {19'h00000, irq_r} :
        hit_stat ? stat_word : 32'h0000_0000;

    // Capture write address; read data is fetched in the address phase
    // Early fetch keeps zero wait; a read right after a write
    // to the same word still returns the old value
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            hrdata <= 32'h0000_0000;
        end else begin
            wr_pend_r <= addr_ok && hwrite && word_ok;
            wr_addr_r <= haddr[7:0];
            if (addr_ok && !hwrite) begin
                hrdata <= rd_word;
            end
        end
    end

    // Zero-wait OKAY slave; unmapped reads return zero
    // Kept as flops so both outputs leave straight from a register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // Control and routing registers written in the data phase
    // A narrow write is dropped whole, never merged into the word
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_r <= pcm_pkg::CTRL_RST;
            irq_r <= pcm_pkg::IRQ_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl_r <= hwdata[pcm_pkg::CTRL_WIDTH-1:0];
            end
            if (wr_irq) begin
                irq_r <= hwdata[pcm_pkg::IRQ_WIDTH-1:0];
            end
        end
    end

    // ****************************************************************
    // Pin redefinition
    // ****************************************************************
    // Pin meanings are pure decode of straps and control bits
    // They move only on a control write or a strap reload
    wire card_is_io = ctrl_r[pcm_pkg::CTRL_IO_BIT];
    wire dma_dev = ctrl_r[pcm_pkg::CTRL_DMA_DEV_BIT];
    wire dma_on = dma_dev && ctrl_r[pcm_pkg::CTRL_DMA_EN_BIT];
    wire five_v_only = ctrl_r[pcm_pkg::CTRL_5V_ONLY_BIT];
    wire ext_vsense = ctrl_r[pcm_pkg::CTRL_EXT_VS_BIT];
    wire extended = !spkr_strap;

    // Sense-one pin as EEPROM select wins over every other use
    // In select mode the pin reads back our own drive
    // It must never pass as a host acknowledge
    wire eecs_mode = extended && !s1_strap;
    // Allowed system setups for the acknowledge pass-through
    wire dack_allowed = five_v_only || (!extended && ext_vsense) ||
        (extended && s1_strap);
    wire dack_path = dma_on && dack_allowed && !eecs_mode;

    // Write-protect pin meaning by card type and DMA use
    wire wp_is_dreq = dma_dev;
    wire wp_is_io16 = card_is_io && !dma_dev;
    wire io_is16 = wp_is_io16 && !card_wp;
    wire card_dreq = wp_is_dreq && !card_wp;

    // Sense-one pin driver; input-only unless used as chip select
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sock_b_volt_sense_one_oe <= 1'b0;
            sock_b_volt_sense_one_o <= 1'b0;
        end else begin
            sock_b_volt_sense_one_oe <= eecs_mode;
            sock_b_volt_sense_one_o <= eecs_mode && eeprom_chip_select;
        end
    end

    // Attribute select carries host acknowledge in DMA pass-through
    // One clock of lag is harmless; the host holds the ack
    // for the whole transfer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            card_reg_n <= 1'b1;
        end else begin
            card_reg_n <= dack_path ? sock_b_volt_sense_one_i : mem_attr_sel_n;
        end
    end

    // DMA handshake pair and terminal count toward host and card
    // Request is active low on the pin, high toward the host
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            host_dreq <= 1'b0;
            card_tc <= 1'b0;
        end else begin
            host_dreq <= dma_on && card_dreq;
            card_tc <= dma_on && host_tc;
        end
    end

    // Write-protect switch status only has meaning for memory cards
    // A card with no switch ties the pin to a fixed level
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wp_status <= 1'b0;
        end else begin
            wp_status <= !card_is_io && !dma_dev && card_wp;
        end
    end

    // ****************************************************************
    // Interrupt routing onto ten host lines
    // ****************************************************************
    wire [3:0] card_sel = irq_r[pcm_pkg::IRQ_CARD_LSB +: 4];
    wire [3:0] sts_sel = irq_r[pcm_pkg::IRQ_STS_LSB +: 4];
    wire card_en = irq_r[pcm_pkg::IRQ_CARD_EN_BIT];
    wire sts_en = irq_r[pcm_pkg::IRQ_STS_EN_BIT];
    // Card interrupt line exists only for I/O cards
    wire card_int = card_is_io && !card_irq_n;
    logic [9:0] irq_nxt;

    // Route selections of ten or above reach no line
    // Both sources may pick one line; they are ORed
    always_comb begin
        irq_nxt = 10'h000;
        for (int i = 0; i < pcm_pkg::IRQ_NUM; i++) begin
            irq_nxt[i] = (card_en && card_int && (card_sel == 4'(i))) ||
                (sts_en && sts_change && (sts_sel == 4'(i)));
        end
    end

    // Registered so each host line leaves from a flop
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            host_irq <= 10'h000;
        end else begin
            host_irq <= irq_nxt;
        end
    end

    // ****************************************************************
    // Card cycle control
    // ****************************************************************
    logic seq_busy;

    // Width and zero-wait choices are taken at the start edge
    pcm_cycle_ctl u_cycle (
        .hclk(hclk),
        .hresetn(hresetn),
        .cyc_start(cyc_start),
        .cyc_io(cyc_io),
        .cyc_wide(cyc_wide),
        .win_8bit(win_8bit),
        .io_is16(io_is16),
        .card_is_io(card_is_io),
        .zws_req(zws_req),
        .card_wait_n(card_wait_n),
        .cmd_active(card_cmd_active),
        .odd_byte(card_odd_byte),
        .zws_n(host_zws_n),
        .cyc_done(cyc_done),
        .busy(seq_busy)
    );

    // Status word shows straps, pin meanings and sequencer activity
    // Read-only; a write to this offset is dropped
    assign stat_word = {
        23'h000000,
        seq_busy,
        eecs_mode,
        dack_path,
        card_dreq,
        io_is16,
        wp_status,
        sock_b_volt_sense_one_i,
        s1_strap,
        spkr_strap
    };
endmodule

// ===== pcm_pkg.sv
// Shared constants and types for the PC Card socket signal multiplexer
package pcm_pkg;
    // ****************************************************************
    // Register map (byte addresses, one word each)
    // ****************************************************************
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] IRQ_OFS = 8'h04;
    localparam logic [7:0] STAT_OFS = 8'h08;

    // Control register fields
    localparam int CTRL_IO_BIT = 0;
    localparam int CTRL_DMA_DEV_BIT = 1;
    localparam int CTRL_DMA_EN_BIT = 2;
    localparam int CTRL_5V_ONLY_BIT = 3;
    localparam int CTRL_EXT_VS_BIT = 4;
    localparam int CTRL_WIDTH = 5;
    localparam logic [4:0] CTRL_RST = 5'h00;

    // Interrupt routing fields
    localparam int IRQ_CARD_LSB = 0;
    localparam int IRQ_CARD_EN_BIT = 4;
    localparam int IRQ_STS_LSB = 8;
    localparam int IRQ_STS_EN_BIT = 12;
    localparam int IRQ_WIDTH = 13;
    localparam logic [12:0] IRQ_RST = 13'h0000;
    localparam int IRQ_NUM = 10;

    // Status register fields
    localparam int STAT_SPKR_STRAP_BIT = 0;
    localparam int STAT_S1_STRAP_BIT = 1;
    localparam int STAT_SENSE_BIT = 2;
    localparam int STAT_WP_BIT = 3;
    localparam int STAT_IO16_BIT = 4;
    localparam int STAT_DREQ_BIT = 5;
    localparam int STAT_DACK_PATH_BIT = 6;
    localparam int STAT_EECS_MODE_BIT = 7;
    localparam int STAT_BUSY_BIT = 8;

    // Strap reset values (pins pulled high when unstrapped)
    localparam logic SPKR_STRAP_RST = 1'b1;
    localparam logic S1_STRAP_RST = 1'b1;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_NS = 20;
    localparam int CMD_MIN_NS = 60;
    localparam int CMD_MIN_CYC = (CMD_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [3:0] CMD_CNT_INIT = 4'(CMD_MIN_CYC - 1);

    // Card cycle sequencer states
    typedef enum logic [1:0] {
        CYC_IDLE,
        CYC_STROBE,
        CYC_GAP
    } pcm_cyc_e;
endpackage

// ===== pcm_strap_latch.sv
// Strap capture: follows a pin while host bus reset is high, holds it after
`timescale 1ns/1ps
module pcm_strap_latch #(
    parameter logic RST_VAL = 1'b1
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic bus_reset,
    input wire logic pin,
    output logic strap
);
    // Track during reset so the value at the falling edge is what stays
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            strap <= RST_VAL;
        end else if (bus_reset) begin
            strap <= pin;
        end
    end
endmodule

// ===== pcm_cycle_ctl.sv
// Card cycle sequencer: strobe timing, wait hold-off, byte split, zero wait
`timescale 1ns/1ps
module pcm_cycle_ctl (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic cyc_start,
    input wire logic cyc_io,
    input wire logic cyc_wide,
    input wire logic win_8bit,
    input wire logic io_is16,
    input wire logic card_is_io,
    input wire logic zws_req,
    input wire logic card_wait_n,
    output logic cmd_active,
    output logic odd_byte,
    output logic zws_n,
    output logic cyc_done,
    output logic busy
);
    pcm_pkg::pcm_cyc_e state_r;
    logic [3:0] cnt_r;
    logic split_r;

    // An 8-bit window ignores the port-width indication entirely
    wire is16_seen = io_is16 && !win_8bit;
    // Wide I/O to an I/O card without a 16-bit port becomes two byte cycles
    wire split_nxt = cyc_io && cyc_wide && card_is_io && !is16_seen;
    wire wide_io = cyc_io && cyc_wide && !split_nxt;
    // Zero wait is never offered on a true 16-bit I/O access
    wire zws_ok = zws_req && !wide_io;
    wire cnt_zero = (cnt_r == 4'h0);

    // Sequencer; new starts while busy are ignored by design
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r <= pcm_pkg::CYC_IDLE;
            cnt_r <= 4'h0;
            split_r <= 1'b0;
            cmd_active <= 1'b0;
            odd_byte <= 1'b0;
            zws_n <= 1'b1;
            cyc_done <= 1'b0;
            busy <= 1'b0;
        end else begin
            cyc_done <= 1'b0;
            case (state_r)
                pcm_pkg::CYC_IDLE: begin
                    if (cyc_start) begin
                        state_r <= pcm_pkg::CYC_STROBE;
                        cnt_r <= pcm_pkg::CMD_CNT_INIT;
                        split_r <= split_nxt;
                        cmd_active <= 1'b1;
                        odd_byte <= 1'b0;
                        zws_n <= !zws_ok;
                        busy <= 1'b1;
                    end
                end
                pcm_pkg::CYC_STROBE: begin
                    if (!cnt_zero) begin
                        cnt_r <= cnt_r - 4'h1;
                    end else if (!card_wait_n) begin
                        // Card holds the cycle; stop promising an early end
                        zws_n <= 1'b1;
                    end else if (split_r && !odd_byte) begin
                        state_r <= pcm_pkg::CYC_GAP;
                        cmd_active <= 1'b0;
                        zws_n <= 1'b1;
                    end else begin
                        state_r <= pcm_pkg::CYC_IDLE;
                        cmd_active <= 1'b0;
                        zws_n <= 1'b1;
                        cyc_done <= 1'b1;
                        busy <= 1'b0;
                    end
                end
                pcm_pkg::CYC_GAP: begin
                    // One idle cycle between even and odd byte strobes
                    state_r <= pcm_pkg::CYC_STROBE;
                    cnt_r <= pcm_pkg::CMD_CNT_INIT;
                    cmd_active <= 1'b1;
                    odd_byte <= 1'b1;
                end
                default: begin
                    state_r <= pcm_pkg::CYC_IDLE;
                end
            endcase
        end
    end
endmodule

// ===== pcm_socket_mux_props.sv
// Concurrent checks on the socket multiplexer's ports
`timescale 1ns/1ps
// ****************************************************************
// Checker
// ****************************************************************
module pcm_socket_mux_chk (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic cyc_start,
    input wire logic cyc_io,
    input wire logic cyc_wide,
    input wire logic win_8bit,
    input wire logic zws_req,
    input wire logic mem_attr_sel_n,
    input wire logic card_wp,
    input wire logic card_wait_n,
    input wire logic eeprom_chip_select,
    input wire logic host_zws_n,
    input wire logic cyc_done,
    input wire logic card_cmd_active,
    input wire logic card_odd_byte,
    input wire logic card_reg_n,
    input wire logic sock_b_volt_sense_one_o,
    input wire logic sock_b_volt_sense_one_oe
);
    logic busy_r;
    logic busy_nxt;
    logic acc;
    // Own view of the sequencer; a start while busy is dropped by the design
    assign acc = cyc_start && (!busy_r || cyc_done);
    assign busy_nxt = acc ? 1'b1 : (cyc_done ? 1'b0 : busy_r);
    // Busy flag follows accepted starts until the done pulse
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            busy_r <= 1'b0;
        end else begin
            busy_r <= busy_nxt;
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Wide I/O start with the port-width indication present (active low)
    sequence s_io16;
        acc && cyc_io && cyc_wide && !win_8bit && !card_wp;
    endsequence
    sequence s_odd;
        card_cmd_active && card_odd_byte;
    endsequence
    // Pin in select mode for two clocks, so one clock of latency is settled
    sequence s_ee;
        sock_b_volt_sense_one_oe && $past(sock_b_volt_sense_one_oe);
    endsequence
    chk_zws_io16: assert property (s_io16 |=> host_zws_n[*4])
        else $error("zero wait driven on a 16-bit I/O access");
    chk_zws_early: assert property (acc && zws_req && !cyc_io && card_wait_n |=> !host_zws_n)
        else $error("zero wait not driven for a memory cycle");
    chk_zws_span: assert property (!host_zws_n |-> busy_r)
        else $error("zero wait outside a cycle");
    chk_wait_hold: assert property (card_cmd_active && !card_wait_n |=> card_cmd_active)
        else $error("strobe ended while card wait low");
    chk_strobe_min: assert property ($rose(card_cmd_active) |-> card_cmd_active[*3])
        else $error("strobe shorter than three clocks");
    chk_done_late: assert property (acc |=> !cyc_done[*3])
        else $error("cycle done too early");
    chk_done_pulse: assert property (cyc_done |-> !card_cmd_active ##1 !cyc_done)
        else $error("done pulse malformed");
    chk_split_gap: assert property ($fell(card_cmd_active) && !cyc_done |=> s_odd)
        else $error("odd byte strobe missing after gap");
    chk_eecs_drive: assert property (s_ee |-> sock_b_volt_sense_one_o == $past(eeprom_chip_select))
        else $error("sense pin not carrying eeprom select");
    chk_eeprom_reg: assert property (s_ee |-> card_reg_n == $past(mem_attr_sel_n))
        else $error("attribute select not from window in eeprom mode");
endmodule
bind pcm_socket_mux pcm_socket_mux_chk u_chk (.*);

// ===== pcm_card_model.sv
// Behavioural card in socket B: wait and write-protect pins
`timescale 1ns/1ps
// ****************************************************************
// Card model
// ****************************************************************
module pcm_card_model (
    input wire logic hclk,
    input wire logic card_cmd_active,
    input wire logic [3:0] wait_len,
    input wire logic wp_lvl,
    output logic card_wait_n,
    output logic card_wp
);
    logic [3:0] cnt_r = 4'h0;
    logic seen_r = 1'b0;
    // Hold wait low for wait_len clocks after each strobe opens
    always_ff @(posedge hclk) begin
        seen_r <= card_cmd_active;
        if (card_cmd_active && !seen_r) begin
            cnt_r <= wait_len;
        end else if (cnt_r != 4'h0) begin
            cnt_r <= cnt_r - 4'h1;
        end
    end
    // Wait has a pull-up on the socket, so it reads high once released
    assign card_wait_n = (cnt_r == 4'h0);
    // One pin carries switch state, port width or request by card type
    assign card_wp = wp_lvl;
endmodule

// ===== pcm_socket_mux_bench.sv
// Self-checking bench for the socket signal multiplexer
`timescale 1ns/1ps
module pcm_socket_mux_bench;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic bus_reset, speaker_out_strap, host_tc, host_dreq, host_zws_n;
    logic [9:0] host_irq;
    logic cyc_start, cyc_io, cyc_wide, win_8bit, zws_req, mem_attr_sel_n, sts_change;
    logic cyc_done, card_cmd_active, card_odd_byte, eeprom_chip_select, card_wp;
    logic sock_b_volt_sense_one_i, sock_b_volt_sense_one_o, sock_b_volt_sense_one_oe;
    logic card_wait_n, card_irq_n, card_reg_n, card_tc, wp_status, sense_drv, wp_lvl;
    logic [3:0] wait_len;
    logic [8:0] r;
    int errors, checked;
    // Rows: ctrl[8:4], speaker strap, sense strap, ack path, select mode
    logic [8:0] rows [7] = '{9'h0EE, 9'h16E, 9'h06C, 9'h066, 9'h061, 9'h0AC, 9'h0E1};
    // Slave is the only one on the bus; the pin level resolves both drivers
    assign hready = hreadyout;
    assign sock_b_volt_sense_one_i = sock_b_volt_sense_one_oe ? sock_b_volt_sense_one_o : sense_drv;
    pcm_socket_mux u_dut (.*);
    pcm_card_model u_card (.hclk(hclk), .card_cmd_active(card_cmd_active),
        .wait_len(wait_len), .wp_lvl(wp_lvl), .card_wait_n(card_wait_n), .card_wp(card_wp));
    // Free-running 50 MHz clock
    always #10 hclk = ~hclk;
    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        if (errors == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // One single word transfer; an idle edge first avoids read-after-write staleness
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        hsize <= 3'h2;
        haddr <= {24'h0, a};
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        q = hrdata;
    endtask
    // Straps reload only from a clean reset, else the driven pin would feed back
    task automatic straps(input logic spk, input logic s1);
        hresetn <= 1'b0;
        bus_reset <= 1'b1;
        speaker_out_strap <= spk;
        sense_drv <= s1;
        eeprom_chip_select <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus_reset <= 1'b0;
        @(posedge hclk);
    endtask
    // Card cycle; f = {io, wide, 8-bit window, zero-wait request}; n counts edges
    task automatic run_cyc(input logic [3:0] f, input logic [3:0] wl, input logic [7:0] en,
                           input logic eo, input logic ez);
        logic [7:0] n;
        logic odd;
        logic zl;
        n = 8'h00;
        odd = 1'b0;
        zl = 1'b0;
        wait_len <= wl;
        {cyc_io, cyc_wide, win_8bit, zws_req} <= f;
        cyc_start <= 1'b1;
        @(posedge hclk);
        cyc_start <= 1'b0;
        do begin
            @(posedge hclk);
            n++;
            odd |= card_odd_byte;
            zl |= !host_zws_n;
        end while (cyc_done !== 1'b1 && n < 8'h28);
        chk(n, en);
        chk(odd, eo);
        chk(zl, ez);
    endtask
    // ****************************************************************
    // Sequence
    // ****************************************************************
    // Watchdog cuts a hang short
    initial begin
        repeat (20000) @(posedge hclk);
        errors++;
        print_verdict();
    end
    initial begin
        {hclk, hresetn, hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
        {bus_reset, speaker_out_strap, host_tc, cyc_start, cyc_io, cyc_wide} = 6'h21;
        {win_8bit, zws_req, mem_attr_sel_n, sts_change, eeprom_chip_select} = 5'h04;
        {card_irq_n, sense_drv, wp_lvl, wait_len} = 7'h60;
        errors = 0;
        checked = 0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        ahb(1'b0, pcm_pkg::CTRL_OFS, 32'h0);
        chk(q, {27'h0, pcm_pkg::CTRL_RST});
        for (int i = 0; i < 7; i++) begin
            r = rows[i];
            straps(r[3], r[2]);
            ahb(1'b1, pcm_pkg::CTRL_OFS, {27'h0, r[8:4]});
            for (int v = 0; v < 2; v++) begin
                sense_drv <= v[0];
                mem_attr_sel_n <= !v[0];
                eeprom_chip_select <= v[0];
                ahb(1'b0, pcm_pkg::STAT_OFS, 32'h0);
                chk(card_reg_n, r[1] ? v[0] : !v[0]);
                chk(sock_b_volt_sense_one_oe, r[0]);
                chk(q & 32'hC7, {24'h0, r[0], r[1], 3'h0, v[0], r[2], r[3]});
            end
        end
        // Register access, unmapped offset, write-protect and DMA pin meanings
        straps(1'b1, 1'b1);
        ahb(1'b1, pcm_pkg::CTRL_OFS, 32'h1F);
        ahb(1'b0, pcm_pkg::CTRL_OFS, 32'h0);
        chk(q, 32'h1F);
        ahb(1'b0, 8'h0C, 32'h0);
        chk(q, 32'h0);
        chk(hresp, 32'h0);
        wp_lvl <= 1'b1;
        ahb(1'b1, pcm_pkg::CTRL_OFS, 32'h0);
        ahb(1'b0, pcm_pkg::STAT_OFS, 32'h0);
        chk({wp_status, q[3], host_dreq, card_tc}, 4'hC);
        wp_lvl <= 1'b0;
        host_tc <= 1'b1;
        ahb(1'b1, pcm_pkg::CTRL_OFS, 32'h06);
        ahb(1'b0, pcm_pkg::STAT_OFS, 32'h0);
        chk({wp_status, q[5], host_dreq, card_tc}, 4'h7);
        host_tc <= 1'b0;
        // Card interrupt routed to lines 0 and 5; out-of-range line 10 routes nowhere
        ahb(1'b1, pcm_pkg::CTRL_OFS, 32'h01);
        card_irq_n <= 1'b0;
        for (int ln = 0; ln < 11; ln += 5) begin
            ahb(1'b1, pcm_pkg::IRQ_OFS, 32'h10 | ln);
            ahb(1'b0, pcm_pkg::IRQ_OFS, 32'h0);
            chk(q, 32'h10 | ln);
            chk(host_irq, 10'(10'h001 << ln));
        end
        card_irq_n <= 1'b1;
        sts_change <= 1'b1;
        ahb(1'b1, pcm_pkg::IRQ_OFS, 32'h1300);
        ahb(1'b0, pcm_pkg::IRQ_OFS, 32'h0);
        chk(host_irq, 10'h008);
        sts_change <= 1'b0;
        // Card cycles: I/O card first, then memory card
        wp_lvl <= 1'b0;
        run_cyc(4'hD, 4'h0, 8'h04, 1'b0, 1'b0);
        run_cyc(4'hE, 4'h0, 8'h08, 1'b1, 1'b0);
        wp_lvl <= 1'b1;
        run_cyc(4'hC, 4'h0, 8'h08, 1'b1, 1'b0);
        ahb(1'b1, pcm_pkg::CTRL_OFS, 32'h0);
        run_cyc(4'h1, 4'h0, 8'h04, 1'b0, 1'b1);
        run_cyc(4'h0, 4'h6, 8'h09, 1'b0, 1'b0);
        print_verdict();
    end
endmodule
